// ===== verilog/tkf_top.sv
`timescale 1ns/1ns
`include "tkf_consts.svh"
module tkf_top #(
  parameter int NCH = `TKF_NCH,
  parameter int MW = `TKF_MAG_W,
  parameter logic [`TKF_MAG_W-1:0] HYST = `TKF_HYST_DEF
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Measurement front end, per channel packed
  input wire logic [NCH*MW-1:0] i_sense_imp,
  input wire logic [NCH*MW-1:0] i_calib_imp,
  input wire logic [NCH*MW-1:0] i_touch_threshold,
  // Byte register port from the serial host interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [NCH-1:0] mask1;
    logic [NCH-1:0] mask2;
    logic [NCH-1:0] live;
    logic [NCH-1:0] filt;
    logic [7:0] rdata;
    logic rvalid;
  } tkf_state_t;
  tkf_state_t st_r;
  tkf_state_t st_nxt;

  //////////////////////////////////////////////////////////////////////////
  logic [NCH*MW-1:0] delta;
  logic [NCH-1:0] live_cmp;
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_cmp
      logic [MW-1:0] s;
      logic [MW-1:0] k;
      logic [MW-1:0] d;
      logic [MW:0] on_lvl;
      assign s = i_sense_imp[c*MW +: MW];
      assign k = i_calib_imp[c*MW +: MW];
      assign d = (s > k) ? s - k : k - s;
      assign delta[c*MW +: MW] = d;
      assign on_lvl = {1'b0, i_touch_threshold[c*MW +: MW]};
      // Hysteresis: release only once the change falls HYST below the threshold
      always_comb begin
        if ({1'b0, d} > on_lvl) begin
          live_cmp[c] = 1'b1;
        end else if ({1'b0, d} + {1'b0, HYST} > on_lvl) begin
          live_cmp[c] = st_r.live[c];
        end else begin
          live_cmp[c] = 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  logic [NCH-1:0] keep1;
  logic [NCH-1:0] keep2;
  tkf_filter_unit #(.NCH(NCH), .MW(MW)) u_unit1 (
    .i_touch(st_r.live),
    .i_mask(st_r.mask1),
    .i_delta(delta),
    .i_mode(st_r.ctrl[`TKF_CTRL_M1_LO +: 2]),
    .o_keep(keep1)
  );
  tkf_filter_unit #(.NCH(NCH), .MW(MW)) u_unit2 (
    .i_touch(st_r.live),
    .i_mask(st_r.mask2),
    .i_delta(delta),
    .i_mode(st_r.ctrl[`TKF_CTRL_M2_LO +: 2]),
    .o_keep(keep2)
  );

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pick(input logic [NCH-1:0] v, input logic [1:0] b);
    logic [31:0] w;
    w = 32'h0;
    w[NCH-1:0] = v;
    pick = w[b*8 +: 8];
  endfunction

  logic [7:0] off;
  always_comb begin
    st_nxt = st_r;
    off = 8'h00;
    st_nxt.live = live_cmp;
    st_nxt.filt = keep1 & keep2;
    st_nxt.rvalid = i_reg_rd;
    if (i_reg_wr) begin
      if (i_reg_addr == `TKF_ADDR_CTRL) begin
        st_nxt.ctrl = i_reg_wdata & `TKF_CTRL_USED;
      end
      for (int b = 0; b < 3; b++) begin
        if (i_reg_addr == `TKF_ADDR_G1 + 8'(b)) begin
          st_nxt.mask1[b*8 +: 8] = i_reg_wdata;
        end
        if (i_reg_addr == `TKF_ADDR_G2 + 8'(b)) begin
          st_nxt.mask2[b*8 +: 8] = i_reg_wdata;
        end
      end
    end
    if (i_reg_rd) begin
      st_nxt.rdata = 8'h00;
      if (i_reg_addr == `TKF_ADDR_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end
      for (int b = 0; b < 3; b++) begin
        off = 8'(b);
        if (i_reg_addr == `TKF_ADDR_G1 + off) st_nxt.rdata = pick(st_r.mask1, 2'(b));
        if (i_reg_addr == `TKF_ADDR_G2 + off) st_nxt.rdata = pick(st_r.mask2, 2'(b));
        if (i_reg_addr == `TKF_ADDR_FILT + off) st_nxt.rdata = pick(st_r.filt, 2'(b));
        if (i_reg_addr == `TKF_ADDR_LIVE + off) st_nxt.rdata = pick(st_r.live, 2'(b));
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata = st_r.rdata;
  assign o_reg_rvalid = st_r.rvalid;

  //////////////////////////////////////////////////////////////////////////
  property p_ctrl_write;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_reg_wr && i_reg_addr == `TKF_ADDR_CTRL) |=> st_r.ctrl == ($past(i_reg_wdata) & 8'h0F);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

  property p_live_on;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (delta[MW-1:0] > i_touch_threshold[MW-1:0]) |=> st_r.live[0];
  endproperty
  a_live_on: assert property (p_live_on) else $error("touch not detected");

  property p_nofilt;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (st_r.ctrl[3:0] == 4'h0) |=> st_r.filt == $past(st_r.live);
  endproperty
  a_nofilt: assert property (p_nofilt) else $error("no-filter mode altered status");

  property p_keep1;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (st_r.ctrl[1:0] == 2'b01) |-> $countones(keep1 & st_r.mask1) <= 1;
  endproperty
  a_keep1: assert property (p_keep1) else $error("unit one kept too many");

  property p_cap2;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      $countones(keep2 & st_r.mask2) <= ((st_r.ctrl[3:2] == 2'b00) ? NCH : st_r.ctrl[3:2]);
  endproperty
  a_cap2: assert property (p_cap2) else $error("unit two kept too many");

  property p_subset;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      ##1 ((st_r.filt & ~$past(st_r.live)) == '0);
  endproperty
  a_subset: assert property (p_subset) else $error("filtered bit without touch");

  property p_read_live;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_reg_rd && i_reg_addr == `TKF_ADDR_LIVE) |=>
        o_reg_rvalid && o_reg_rdata == $past(st_r.live[7:0]);
  endproperty
  a_read_live: assert property (p_read_live) else $error("live byte read wrong");

  property p_mask_wr;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_reg_wr && i_reg_addr == `TKF_ADDR_G2) |=> st_r.mask2[7:0] == $past(i_reg_wdata);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_mask1_hi;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_reg_wr && i_reg_addr == `TKF_ADDR_G1 + 8'h02) |=>
        st_r.mask1[23:16] == $past(i_reg_wdata);
  endproperty
  a_mask1_hi: assert property (p_mask1_hi) else $error("top mask byte lost");

  property p_live_off;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      ({1'b0, delta[MW-1:0]} + {1'b0, HYST}) <= {1'b0, i_touch_threshold[MW-1:0]} |=>
        !st_r.live[0];
  endproperty
  a_live_off: assert property (p_live_off) else $error("touch not released");

  property p_cap1;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (st_r.ctrl[1:0] != 2'b00) |-> $countones(keep1 & st_r.mask1) <= int'(st_r.ctrl[1:0]);
  endproperty
  a_cap1: assert property (p_cap1) else $error("unit one over its cap");

  property p_reserved;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      st_r.ctrl[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved control bits set");

  // Read request, then the answer one cycle later
  sequence s_filt_read;
    i_reg_rd && i_reg_addr == `TKF_ADDR_FILT;
  endsequence
  sequence s_answer_filt;
    o_reg_rvalid && o_reg_rdata == $past(st_r.filt[7:0]);
  endsequence
  property p_read_filt;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      s_filt_read |=> s_answer_filt;
  endproperty
  a_read_filt: assert property (p_read_filt) else $error("filtered byte read wrong");

  property p_rvalid_one;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      !i_reg_rd |=> !o_reg_rvalid && $stable(o_reg_rdata);
  endproperty
  a_rvalid_one: assert property (p_rvalid_one) else $error("read answer without read");
endmodule

// ===== verilog/tkf_consts.svh
`ifndef TKF_CONSTS_SVH
`define TKF_CONSTS_SVH
`define TKF_NCH 24
`define TKF_ADDR_CTRL 8'h90
`define TKF_ADDR_G1 8'h92
`define TKF_ADDR_G2 8'h96
`define TKF_ADDR_FILT 8'h9A
`define TKF_ADDR_LIVE 8'hB4
`define TKF_CTRL_RST 8'h00
`define TKF_MASK_RST 24'h000000
`define TKF_CTRL_M1_LO 0
`define TKF_CTRL_M2_LO 2
`define TKF_CTRL_USED 8'h0F
`define TKF_MAG_W 13
`define TKF_HYST_DEF 13'h0004
`endif

// ===== verilog/tkf_pkg.sv
package tkf_pkg;
  typedef enum logic [1:0] {
    TKF_NOFILT = 2'b00,
    TKF_KEEP1 = 2'b01,
    TKF_KEEP2 = 2'b10,
    TKF_KEEP3 = 2'b11
  } tkf_mode_t;
endpackage

// ===== verilog/tkf_filter_unit.sv
`timescale 1ns/1ns
`include "tkf_consts.svh"
// Combinational top-N selector; the parent registers its result
module tkf_filter_unit #(
  parameter int NCH = `TKF_NCH,
  parameter int MW = `TKF_MAG_W
) (
  // Inputs
  input wire logic [NCH-1:0] i_touch,
  input wire logic [NCH-1:0] i_mask,
  input wire logic [NCH*MW-1:0] i_delta,
  input wire logic [1:0] i_mode,
  // Result
  output logic [NCH-1:0] o_keep
);
  logic [NCH-1:0] in_grp;
  assign in_grp = i_touch & i_mask;
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic [4:0] beaten;
      always_comb begin
        beaten = 5'h00;
        for (int k = 0; k < NCH; k++) begin
          // Equal change: the lower-numbered channel wins
          if (k != c && in_grp[k] &&
              (i_delta[k*MW +: MW] > i_delta[c*MW +: MW] ||
               (i_delta[k*MW +: MW] == i_delta[c*MW +: MW] && k < c))) begin
            beaten = beaten + 5'h01;
          end
        end
      end
      // Channels outside the group pass untouched
      assign o_keep[c] = !i_mask[c] ? i_touch[c] :
                         (i_mode == tkf_pkg::TKF_NOFILT) ? i_touch[c] :
                         (in_grp[c] && beaten < {3'h0, i_mode});
    end
  endgenerate
endmodule

// ===== tb/touchkey_key_filter_tb.sv
`timescale 1ns/1ns
`include "tkf_consts.svh"
module touchkey_key_filter_tb;
  logic i_clk_sys;
  logic i_rstn;
  logic [`TKF_NCH*`TKF_MAG_W-1:0] sense, calib, thr;
  logic wr, rd;
  logic [7:0] addr, wdata;
  logic [7:0] rdata;
  logic rvalid;
  int errors;
  int compares;
  tkf_top tkf_top_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_sense_imp(sense),
    .i_calib_imp(calib), .i_touch_threshold(thr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_clk_sys);
    wr = 1'b0;
  endtask
  // The answer stands for one cycle after the strobe edge, so judge it at the
  // next falling edge; a cycle later valid must drop while the data holds
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk_sys);
    rd = 1'b1;
    addr = a;
    @(negedge i_clk_sys);
    rd = 1'b0;
    chk("rvalid", {7'h00, rvalid}, 8'h01);
    chk($sformatf("reg %h", a), rdata, exp);
    @(negedge i_clk_sys);
    chk("rvalid low", {7'h00, rvalid}, 8'h00);
    chk($sformatf("held %h", a), rdata, exp);
  endtask
  // Calibration is zero unless a test sets it, so sense is the change itself
  task automatic set_d(input int ch, input logic [`TKF_MAG_W-1:0] v);
    sense[ch*`TKF_MAG_W +: `TKF_MAG_W] = v;
  endtask
  task automatic settle();
    repeat (3) @(negedge i_clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [7:0] a [11];
    a = '{8'h90, 8'h92, 8'h93, 8'h94, 8'h96, 8'h98, 8'h9A, 8'h9C, 8'hB4, 8'hB6, 8'h91};
    foreach (a[i]) rd_chk(a[i], 8'h00);
    $display("test reset done");
  endtask
  task automatic test_ctrl();
    wr_reg(`TKF_ADDR_CTRL, 8'hFF);
    rd_chk(`TKF_ADDR_CTRL, 8'h0F);
    wr_reg(8'h9A, 8'hFF);
    rd_chk(8'h9A, 8'h00);
    wr_reg(`TKF_ADDR_CTRL, 8'h00);
    $display("test ctrl done");
  endtask
  task automatic test_live();
    set_d(0, 13'h0014);
    set_d(9, 13'h0014);
    set_d(17, 13'h0014);
    // Sensed below calibration must count by its magnitude
    calib[5*`TKF_MAG_W +: `TKF_MAG_W] = 13'h0014;
    settle();
    rd_chk(8'hB4, 8'h21);
    rd_chk(8'hB5, 8'h02);
    rd_chk(8'hB6, 8'h02);
    rd_chk(8'h9C, 8'h02);
    calib[5*`TKF_MAG_W +: `TKF_MAG_W] = 13'h0000;
    // Inside the hysteresis band the bit must hold, below it clear
    set_d(0, 13'h0008);
    settle();
    rd_chk(8'hB4, 8'h01);
    set_d(0, 13'h0006);
    settle();
    rd_chk(8'hB4, 8'h00);
    set_d(9, 13'h0000);
    set_d(17, 13'h0000);
    $display("test live done");
  endtask
  task automatic test_group_one();
    logic [7:0] exp [4];
    exp = '{8'h1E, 8'h10, 8'h12, 8'h16};
    wr_reg(8'h92, 8'hFF);
    rd_chk(8'h92, 8'hFF);
    set_d(1, 13'h001E);
    set_d(2, 13'h0014);
    set_d(3, 13'h0014);
    set_d(4, 13'h0028);
    set_d(12, 13'h0032);
    // Mode 3 cuts between equal channels 2 and 3
    for (int m = 0; m < 4; m++) begin
      wr_reg(`TKF_ADDR_CTRL, m[7:0]);
      settle();
      rd_chk(8'h9A, exp[m]);
      rd_chk(8'h9B, 8'h10);
    end
    $display("test group one done");
  endtask
  task automatic test_group_two();
    logic [7:0] c [3];
    logic [7:0] lo [3];
    logic [7:0] hi [3];
    c = '{8'h08, 8'h0C, 8'h07};
    lo = '{8'h00, 8'h10, 8'h00};
    hi = '{8'h18, 8'h18, 8'h08};
    wr_reg(`TKF_ADDR_CTRL, 8'h00);
    wr_reg(8'h97, 8'h18);
    set_d(11, 13'h003C);
    wr_reg(`TKF_ADDR_CTRL, 8'h04);
    settle();
    rd_chk(8'h9B, 8'h08);
    rd_chk(8'h9A, 8'h1E);
    // Channels 1 to 4 now sit in both groups and show only where both units keep them
    wr_reg(8'h96, 8'h1E);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`TKF_ADDR_CTRL, c[i]);
      settle();
      rd_chk(8'h9A, lo[i]);
      rd_chk(8'h9B, hi[i]);
    end
    $display("test group two done");
  endtask
  task automatic test_reset_mid();
    wr_reg(8'h94, 8'hA5);
    rd_chk(8'h94, 8'hA5);
    @(negedge i_clk_sys);
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    rd_chk(`TKF_ADDR_CTRL, 8'h00);
    rd_chk(8'h94, 8'h00);
    rd_chk(8'h97, 8'h00);
    settle();
    // Both units fall back to no filtering, so every touch shows again
    rd_chk(8'h9A, 8'h1E);
    rd_chk(8'h9B, 8'h18);
    $display("test mid reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #400000;
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    compares = 0;
    i_rstn = 1'b0;
    sense = '0;
    calib = '0;
    thr = {`TKF_NCH{13'h000A}};
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rstn = 1'b1;
    test_reset();
    test_ctrl();
    test_live();
    test_group_one();
    test_group_two();
    test_reset_mid();
    stop_test();
  end
endmodule
